//--- rtl/mbrm_pkg.sv
// Constants for the request mapper: point blocks, function codes, limits.
// Assumes a single 20 MHz clock domain; no bus registers.
package mbrm_pkg;
  // ----------------------------------------
  // Slave addressing
  // ----------------------------------------
  localparam logic [7:0] ADDR_BCAST = 8'h00;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hf7;
  localparam logic [7:0] ADDR_RSVD = 8'hf7;
  localparam int MAX_SLAVES = 30;
  localparam int MAX_POINTS = 1000;
  // ----------------------------------------
  // Reference digits and function codes
  // ----------------------------------------
  localparam logic [3:0] DIG_COIL = 4'h0;
  localparam logic [3:0] DIG_DISC = 4'h1;
  localparam logic [3:0] DIG_INREG = 4'h3;
  localparam logic [3:0] DIG_HOLD = 4'h4;
  localparam logic [16:0] LOC_MAX = 17'h0ffff;
  localparam logic [7:0] FC_RD_COIL = 8'h01;
  localparam logic [7:0] FC_RD_DISC = 8'h02;
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INREG = 8'h04;
  localparam logic [7:0] FC_WR_ONE_COIL = 8'h05;
  localparam logic [7:0] FC_WR_ONE_REG = 8'h06;
  localparam logic [7:0] FC_WR_COILS = 8'h0f;
  localparam logic [7:0] FC_WR_REGS = 8'h10;
  localparam logic [15:0] QTY_ONE = 16'h0001;
  localparam logic [15:0] QTY_TWO = 16'h0002;
  localparam logic [16:0] LOC_ONE = 17'h00001;
  typedef enum logic [1:0] {MBRM_COIL, MBRM_DISC, MBRM_INREG, MBRM_HOLD}
    mbrm_block_t;
endpackage

//--- rtl/mbrm_mapper.sv
// Request mapper: turns a six-digit point reference into slave address,
// zero-based wire address, quantity and function code.
// Assumes requests come from logic on the same clock; one request at a time.

// Function
// - Unicast slave addresses 1..246 only; address 0 is broadcast to all.
// - Master has no own address; address 247 is reserved, never assigned.
// - At most 30 attached slaves, each with a distinct valid address.
// - At most 1000 enabled points; only those are polled or written.
// - Four data blocks, each location selected by a 16-bit address.
// - Coils and discrete inputs are 1 bit; registers are 16 bits.
// - A 32-bit value takes two adjacent registers, accessed together.
// - Six-digit reference: block digit 0,1,3,4, then five-digit location.
// - Wire address is the one-based location minus one.
// - Reads use codes 1 coils, 2 discretes, 3 holding, 4 input registers.
// - Writes use 15 for coils and 16 for registers, never 5 or 6.
// - Slaves without multi-register reads get one register per request; the mapper splits only wide reads, wide writes to them still carry two.
// - Each attached slave shows upstream as its own device instance.
module mbrm_mapper #(
  parameter int SLAVES = mbrm_pkg::MAX_SLAVES,
  parameter int POINTS = mbrm_pkg::MAX_POINTS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  // Slave table load
  input wire logic slv_load_in,
  input wire logic [4:0] slv_idx_in,
  input wire logic [7:0] slv_addr_in,
  input wire logic slv_multi_in,
  input wire logic slv_en_in,
  output logic slv_load_ok_out,
  output logic slv_load_err_out,
  // Point enable count
  input wire logic pt_enable_in,
  input wire logic pt_disable_in,
  output logic pt_full_out,
  output logic [9:0] pt_count_out,
  // Request
  input wire logic req_valid_in,
  input wire logic [4:0] req_slave_in,
  input wire logic [3:0] req_digit_in,
  input wire logic [16:0] req_loc_in,
  input wire logic req_write_in,
  input wire logic req_wide_in,
  input wire logic req_bcast_in,
  input wire logic req_enabled_in,
  // Issued frame
  output logic out_valid_out,
  output logic [7:0] out_slave_out,
  output logic [7:0] out_func_out,
  output logic [15:0] out_addr_out,
  output logic [15:0] out_qty_out,
  output logic [4:0] out_inst_out,
  output logic out_bit_wide_out,
  output logic req_reject_out
);
  // Slot index and count widths only serve the documented limits
  if (SLAVES < 1 || SLAVES > mbrm_pkg::MAX_SLAVES)
    $error("SLAVES out of range");
  if (POINTS < 1 || POINTS > mbrm_pkg::MAX_POINTS)
    $error("POINTS out of range");

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a >= mbrm_pkg::ADDR_MIN) && (a < mbrm_pkg::ADDR_RSVD);
  endfunction

  function automatic logic [7:0] read_fc(input logic [3:0] d);
    case (d)
      mbrm_pkg::DIG_COIL: read_fc = mbrm_pkg::FC_RD_COIL;
      mbrm_pkg::DIG_DISC: read_fc = mbrm_pkg::FC_RD_DISC;
      mbrm_pkg::DIG_HOLD: read_fc = mbrm_pkg::FC_RD_HOLD;
      default: read_fc = mbrm_pkg::FC_RD_INREG;
    endcase
  endfunction

  // ----------------------------------------
  // Slave table
  // ----------------------------------------
  logic [7:0] tab_addr_q [SLAVES];
  logic [SLAVES-1:0] tab_en_q;
  logic [SLAVES-1:0] tab_multi_q;
  logic dup_d;
  logic load_good_d;

  always_comb
  begin
    dup_d = 1'b0;
    for (int i = 0; i < SLAVES; i++)
      if (tab_en_q[i] && tab_addr_q[i] == slv_addr_in &&
          i != int'(slv_idx_in))
        dup_d = 1'b1;
  end

  // Index past the table refuses the load; bad address or duplicate refuses only an enabling load
  assign load_good_d = (int'(slv_idx_in) < SLAVES) &&
    (!slv_en_in || (addr_ok(slv_addr_in) && !dup_d));

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tab_en_q <= '0;
      tab_multi_q <= '0;
      for (int i = 0; i < SLAVES; i++)
        tab_addr_q[i] <= mbrm_pkg::ADDR_BCAST;
    end
    else if (slv_load_in && load_good_d)
    begin
      tab_en_q[slv_idx_in] <= slv_en_in;
      tab_multi_q[slv_idx_in] <= slv_multi_in;
      tab_addr_q[slv_idx_in] <= slv_addr_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      slv_load_ok_out <= 1'b0;
      slv_load_err_out <= 1'b0;
    end
    else
    begin
      slv_load_ok_out <= slv_load_in && load_good_d;
      slv_load_err_out <= slv_load_in && !load_good_d;
    end
  end

  // ----------------------------------------
  // Enabled point count
  // ----------------------------------------
  logic [9:0] pt_cnt_q;
  assign pt_full_out = (int'(pt_cnt_q) >= POINTS);
  assign pt_count_out = pt_cnt_q;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      pt_cnt_q <= '0;
    else if (pt_enable_in && !pt_disable_in && !pt_full_out)
      pt_cnt_q <= pt_cnt_q + 10'h001;
    else if (pt_disable_in && !pt_enable_in && pt_cnt_q != '0)
      pt_cnt_q <= pt_cnt_q - 10'h001;
  end

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  logic slot_ok_d;
  logic digit_ok_d;
  logic loc_ok_d;
  logic is_reg_d;
  logic write_ok_d;
  logic accept_d;
  logic [7:0] fc_d;
  logic [15:0] qty_d;
  logic [15:0] wire_addr_d;

  assign slot_ok_d = (int'(req_slave_in) < SLAVES) &&
    tab_en_q[req_slave_in];
  assign digit_ok_d = (req_digit_in == mbrm_pkg::DIG_COIL) ||
    (req_digit_in == mbrm_pkg::DIG_DISC) ||
    (req_digit_in == mbrm_pkg::DIG_INREG) ||
    (req_digit_in == mbrm_pkg::DIG_HOLD);
  // Wide value needs the second location still inside the 16-bit space
  assign loc_ok_d = (req_loc_in != '0) && (req_loc_in <= mbrm_pkg::LOC_MAX)
    && !(req_wide_in && req_loc_in == mbrm_pkg::LOC_MAX);
  assign is_reg_d = (req_digit_in == mbrm_pkg::DIG_INREG) ||
    (req_digit_in == mbrm_pkg::DIG_HOLD);
  // Only coils and holding registers are writable
  assign write_ok_d = !req_write_in || req_digit_in == mbrm_pkg::DIG_COIL
    || req_digit_in == mbrm_pkg::DIG_HOLD;
  // Broadcast only for writes, since nobody answers a broadcast read
  assign accept_d = req_valid_in && req_enabled_in && digit_ok_d &&
    loc_ok_d && write_ok_d && (req_bcast_in ? req_write_in : slot_ok_d)
    && !(req_wide_in && !is_reg_d);

  always_comb
  begin
    if (req_write_in)
      fc_d = is_reg_d ? mbrm_pkg::FC_WR_REGS : mbrm_pkg::FC_WR_COILS;
    else
      fc_d = read_fc(req_digit_in);
  end

  // Wide value: two registers at once, or one at a time for reads from simple slaves
  assign qty_d = (req_wide_in && (req_write_in || tab_multi_q[req_slave_in]))
    ? mbrm_pkg::QTY_TWO : mbrm_pkg::QTY_ONE;
  assign wire_addr_d = 16'(req_loc_in - mbrm_pkg::LOC_ONE);

  // ----------------------------------------
  // Issue; split wide read for single-read slaves
  // ----------------------------------------
  logic second_q;
  logic [15:0] second_addr_q;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      out_valid_out <= 1'b0;
      out_slave_out <= mbrm_pkg::ADDR_BCAST;
      out_func_out <= 8'h00;
      out_addr_out <= 16'h0000;
      out_qty_out <= 16'h0000;
      out_inst_out <= 5'h00;
      out_bit_wide_out <= 1'b0;
      req_reject_out <= 1'b0;
      second_q <= 1'b0;
      second_addr_q <= 16'h0000;
    end
    else
    begin
      req_reject_out <= req_valid_in && !accept_d && !second_q;
      if (second_q)
      begin
        out_valid_out <= 1'b1;
        out_addr_out <= second_addr_q;
        second_q <= 1'b0;
      end
      else if (accept_d)
      begin
        out_valid_out <= 1'b1;
        out_slave_out <= req_bcast_in ? mbrm_pkg::ADDR_BCAST
                                      : tab_addr_q[req_slave_in];
        out_func_out <= fc_d;
        out_addr_out <= wire_addr_d;
        out_qty_out <= qty_d;
        out_inst_out <= req_slave_in;
        out_bit_wide_out <= is_reg_d;
        second_q <= req_wide_in && qty_d == mbrm_pkg::QTY_ONE;
        second_addr_q <= 16'(wire_addr_d + 16'h0001);
      end
      else
        out_valid_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence acc_s;
    accept_d && !second_q;
  endsequence

  uni_addr_a: assert property (out_valid_out && out_slave_out != 8'h00 |->
    out_slave_out >= 8'h01 && out_slave_out < 8'hf7)
    else $error("unicast address out of range");
  never_five_a: assert property (out_valid_out |->
    out_func_out != 8'h05 && out_func_out != 8'h06)
    else $error("single write code issued");
  wire_addr_a: assert property (acc_s |=>
    out_addr_out == 16'($past(req_loc_in) - 17'h00001))
    else $error("wire address not location minus one");
  read_fc_a: assert property ((acc_s and (!req_write_in &&
    req_digit_in == 4'h4)) |=> out_func_out == 8'h03)
    else $error("holding read code wrong");
  write_fc_a: assert property ((acc_s and (req_write_in &&
    req_digit_in == 4'h0)) |=> out_func_out == 8'h0f)
    else $error("coil write code wrong");
  reject_bad_a: assert property (req_valid_in && !second_q &&
    (req_loc_in == '0 || req_digit_in == 4'h2) |=>
    req_reject_out && !out_valid_out)
    else $error("bad reference not rejected");
  split_read_a: assert property ((acc_s and (req_wide_in && !req_write_in &&
    !tab_multi_q[req_slave_in])) |=> out_valid_out ##1
    (out_valid_out && out_addr_out == 16'($past(out_addr_out) + 16'h0001)))
    else $error("wide read not split into two");
  pt_limit_a: assert property (pt_full_out |=>
    pt_cnt_q <= $past(pt_cnt_q))
    else $error("point count passed limit");
  dup_refuse_a: assert property (slv_load_in && slv_en_in && dup_d |=>
    slv_load_err_out && !slv_load_ok_out)
    else $error("duplicate slave address accepted");
  inst_a: assert property ((acc_s and !req_bcast_in) |=>
    out_inst_out == $past(req_slave_in))
    else $error("instance not the slave slot");
endmodule

//--- test/mbrm_slave_model.sv
// Far-side model: two slaves that count the frames they would accept.
// Assumes frames arrive as one-cycle valid pulses on the bench clock.
module mbrm_slave_model #(
  parameter logic [7:0] ADDR_A = 8'h05,
  parameter logic [7:0] ADDR_B = 8'h09
) (
  input wire logic clk_in,
  input wire logic valid_in,
  input wire logic [7:0] slave_in,
  output logic [7:0] hits_a_out,
  output logic [7:0] hits_b_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Distinct addresses per slave, so only a broadcast frame lands on both
  initial
  begin
    hits_a_out = 8'h00;
    hits_b_out = 8'h00;
  end
  // Broadcast reaches every slave
  always @(posedge clk_in)
  begin
    if (valid_in && (slave_in == ADDR_A || slave_in == 8'h00))
      hits_a_out <= hits_a_out + 8'h01;
    if (valid_in && (slave_in == ADDR_B || slave_in == 8'h00))
      hits_b_out <= hits_b_out + 8'h01;
  end
endmodule

//--- test/tb.sv
// Self-checking bench for the request mapper.
// Assumes slot 0 holds a single-read slave, slot 1 a multi-read slave.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PTS = 4;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic slv_load_in = 1'b0, slv_multi_in = 1'b0, slv_en_in = 1'b0;
  logic [4:0] slv_idx_in = 5'h00, req_slave_in = 5'h00;
  logic [7:0] slv_addr_in = 8'h00;
  logic pt_enable_in = 1'b0, pt_disable_in = 1'b0, req_valid_in = 1'b0;
  logic [3:0] req_digit_in = 4'h0;
  logic [16:0] req_loc_in = 17'h00001;
  logic req_write_in = 1'b0, req_wide_in = 1'b0, req_bcast_in = 1'b0;
  logic req_enabled_in = 1'b1;
  logic slv_load_ok_out, slv_load_err_out, pt_full_out, out_valid_out;
  logic out_bit_wide_out, req_reject_out;
  logic [9:0] pt_count_out;
  logic [7:0] out_slave_out, out_func_out, hits_a, hits_b;
  logic [15:0] out_addr_out, out_qty_out;
  logic [4:0] out_inst_out;
  int error_cnt = 0;
  int tests_run = 0;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  mbrm_mapper #(.POINTS(PTS)) i_dut (.clk_in, .rst_in, .slv_load_in,
    .slv_idx_in, .slv_addr_in, .slv_multi_in, .slv_en_in, .slv_load_ok_out,
    .slv_load_err_out, .pt_enable_in, .pt_disable_in, .pt_full_out,
    .pt_count_out, .req_valid_in, .req_slave_in, .req_digit_in, .req_loc_in,
    .req_write_in, .req_wide_in, .req_bcast_in, .req_enabled_in,
    .out_valid_out, .out_slave_out, .out_func_out, .out_addr_out,
    .out_qty_out, .out_inst_out, .out_bit_wide_out, .req_reject_out);
  mbrm_slave_model i_slv (.clk_in, .valid_in(out_valid_out),
    .slave_in(out_slave_out), .hits_a_out(hits_a), .hits_b_out(hits_b));
  always #25 clk_in = ~clk_in;
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic load(input logic [4:0] idx, input logic [7:0] adr,
      input logic multi, input logic ok);
    @(posedge clk_in);
    slv_load_in <= 1'b1;
    slv_en_in <= 1'b1;
    slv_idx_in <= idx;
    slv_addr_in <= adr;
    slv_multi_in <= multi;
    @(posedge clk_in);
    slv_load_in <= 1'b0;
    #1;
    chk({slv_load_ok_out, slv_load_err_out}, {ok, !ok});
  endtask
  // Request is held for exactly one edge; outputs sampled just after the next
  task automatic req(input logic [4:0] slot, input logic [3:0] dig,
      input logic [16:0] loc, input logic [2:0] wbe);
    @(posedge clk_in);
    req_valid_in <= 1'b1;
    req_slave_in <= slot;
    req_digit_in <= dig;
    req_loc_in <= loc;
    {req_write_in, req_wide_in, req_bcast_in} <= wbe;
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    #1;
  endtask
  task automatic frame(input logic [7:0] sl, fc, input logic [15:0] ad, qt);
    chk({out_valid_out, req_reject_out, out_slave_out, out_func_out},
        {2'b10, sl, fc});
    chk({out_addr_out, out_qty_out}, {ad, qt});
  endtask
  task automatic pt(input logic up);
    @(posedge clk_in);
    pt_enable_in <= up;
    pt_disable_in <= !up;
    @(posedge clk_in);
    pt_enable_in <= 1'b0;
    pt_disable_in <= 1'b0;
    #1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_table;
    load(5'h00, 8'h05, 1'b0, 1'b1);
    load(5'h01, 8'h09, 1'b1, 1'b1);
    load(5'h02, 8'hf7, 1'b0, 1'b0);
    load(5'h02, 8'h00, 1'b0, 1'b0);
    load(5'h02, 8'h05, 1'b0, 1'b0);
    load(5'h1e, 8'h0c, 1'b0, 1'b0);
  endtask
  task automatic t_reads;
    logic [3:0] dig [4] = '{4'h0, 4'h1, 4'h3, 4'h4};
    logic [7:0] fc [4] = '{8'h01, 8'h02, 8'h04, 8'h03};
    logic [7:0] sa [2] = '{8'h05, 8'h09};
    for (int i = 0; i < 4; i++)
    begin
      req(5'(i % 2), dig[i], 17'h0ffff - 17'(i), 3'b000);
      frame(sa[i % 2], fc[i], 16'hfffe - 16'(i), 16'h1);
      chk({out_inst_out, out_bit_wide_out}, {4'h0, i[0], i[1]});
    end
  endtask
  task automatic t_writes;
    req(5'h00, 4'h0, 17'h00001, 3'b100);
    frame(8'h05, 8'h0f, 16'h0000, 16'h0001);
    req(5'h01, 4'h4, 17'h00002, 3'b100);
    frame(8'h09, 8'h10, 16'h0001, 16'h0001);
    req(5'h00, 4'h4, 17'h00003, 3'b101);
    frame(8'h00, 8'h10, 16'h0002, 16'h0001);
    req(5'h00, 4'h4, 17'h0000a, 3'b110);
    frame(8'h05, 8'h10, 16'h0009, 16'h0002);
  endtask
  task automatic t_wide;
    req(5'h01, 4'h3, 17'h00064, 3'b010);
    frame(8'h09, 8'h04, 16'h0063, 16'h0002);
    req(5'h00, 4'h4, 17'h00064, 3'b010);
    frame(8'h05, 8'h03, 16'h0063, 16'h0001);
    @(posedge clk_in);
    #1;
    frame(8'h05, 8'h03, 16'h0064, 16'h0001);
    // The slave model counts a frame at the edge after it is issued
    @(posedge clk_in);
    #1;
    chk({hits_a, hits_b}, {8'h07, 8'h05});
  endtask
  task automatic t_reject;
    logic [3:0] dig [7] = '{4'h2, 4'h4, 4'h1, 4'h4, 4'h0, 4'h4, 4'h4};
    logic [16:0] loc [7] = '{17'h1, 17'h0, 17'h1, 17'h1, 17'h1, 17'h0ffff,
      17'h10000};
    logic [2:0] wbe [7] = '{3'b000, 3'b000, 3'b100, 3'b001, 3'b010, 3'b010,
      3'b000};
    for (int i = 0; i < 7; i++)
    begin
      req(5'h00, dig[i], loc[i], wbe[i]);
      chk({out_valid_out, req_reject_out}, 2'b01);
    end
    @(posedge clk_in);
    req_enabled_in <= 1'b0;
    req(5'h00, 4'h4, 17'h00001, 3'b000);
    chk({out_valid_out, req_reject_out}, 2'b01);
    @(posedge clk_in);
    req_enabled_in <= 1'b1;
  endtask
  // Small point limit keeps the fill short
  task automatic t_points;
    repeat (PTS + 1) pt(1'b1);
    chk({pt_full_out, pt_count_out}, {1'b1, 10'(PTS)});
    pt(1'b0);
    chk({pt_full_out, pt_count_out}, {1'b0, 10'(PTS - 1)});
  endtask
  initial
  begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    t_table();
    t_reads();
    t_writes();
    t_wide();
    t_reject();
    t_points();
    close_out();
  end
  initial
  begin
    #100000;
    error_cnt++;
    close_out();
  end
endmodule
